// >>> dv/pss_operands.sv
// Purpose: logic operands driving the selector controls
// Assumes: called right after a rising clock edge
// Notes: pulse spacing shortened to keep the run brief
`timescale 1ns/10ps
module pss_operands (
	input wire logic clock,
	output wire logic increment,
	output wire logic increment_confirm,
	output wire logic code_bit_0,
	output wire logic code_bit_1,
	output wire logic code_bit_2,
	output wire logic code_confirm
);
	localparam int HOLD = 3;
	logic [2:0] edges;
	logic [2:0] code;
	initial begin
		edges <= 3'h0;
		code <= 3'h0;
	end
	assign increment = edges[0];
	assign increment_confirm = edges[1];
	assign code_confirm = edges[2];
	assign {code_bit_2, code_bit_1, code_bit_0} = code;
	// 0 step, 1 step confirm, 2 code confirm
	task automatic pulse(input int i);
		edges[i] <= 1'b1;
		repeat (HOLD) @(posedge clock);
		edges[i] <= 1'b0;
		repeat (HOLD) @(posedge clock);
	endtask
	task automatic set_code(input logic [2:0] c);
		code <= c;
		repeat (HOLD) @(posedge clock);
	endtask
endmodule

// >>> dv/pss_selector_properties.sv
// Purpose: port checks for the selector
// Assumes: one clock, reset active low
// Notes: alarm length watched over its first cycles
`timescale 1ns/10ps
module pss_selector_properties (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic [7:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [7:1] positionOut,
	input wire logic [2:0] positionCode,
	input wire logic selector_alarm,
	input wire logic increment_unconfirmed_alarm,
	input wire logic startup_alarm,
	input wire logic eventStrobe
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	wire logic [7:0] hotFull;
	wire logic badAddr;
	assign hotFull = 8'h01 << positionCode;
	assign badAddr = paddr != 8'h00 && paddr != 8'h04 && paddr != 8'h08
		&& paddr != 8'h0C;
	sequence selHeld;
		selector_alarm [*8];
	endsequence
	sequence incHeld;
		increment_unconfirmed_alarm [*8];
	endsequence
	onehot_code_a: assert property (positionOut == hotFull[7:1])
		else $error("one-hot output disagrees with code");
	sel_hold_a: assert property ($rose(selector_alarm) |-> selHeld)
		else $error("range alarm dropped early");
	inc_hold_a: assert property ($rose(increment_unconfirmed_alarm)
		|-> incHeld)
		else $error("step alarm dropped early");
	sel_nomove_a: assert property ($rose(selector_alarm)
		|-> $stable(positionCode) ##1 $stable(positionCode))
		else $error("position moved on range alarm");
	strobe_pulse_a: assert property (eventStrobe |=> !eventStrobe)
		else $error("event strobe longer than a cycle");
	start_zero_a: assert property ($rose(startup_alarm)
		|-> ##[0:3] positionOut == 7'h00)
		else $error("startup alarm without position zero");
	apb_ready_a: assert property (psel && penable |-> pready)
		else $error("access phase without ready");
	apb_err_a: assert property (psel && penable && badAddr |-> pslverr)
		else $error("unmapped access without error");
endmodule

// >>> dv/test_position_selector_switch.sv
// Purpose: self-checking bench for the selector
// Assumes: 25 MHz clock, timeout field set to 1 ms, later to 0
// Notes: three second alarms are not waited out
`timescale 1ns/10ps
`include "pss_defs.svh"
module test_position_selector_switch;
	import pss_pkg::*;
	typedef struct packed {
		logic [2:0] code;
		logic [7:1] hot;
	} pss_row_s;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic psel, penable, pwrite, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic pready, pslverr, increment, increment_confirm, code_confirm;
	logic code_bit_0, code_bit_1, code_bit_2, pendingChange, eventStrobe;
	logic [7:1] positionOut;
	logic [2:0] positionCode, pendingFrom, pendingTo;
	logic selector_alarm, increment_unconfirmed_alarm;
	logic code_unconfirmed_alarm, startup_alarm;
	pss_evt_e eventKind, lastKind = EV_NONE;
	int nMismatch = 0, samplesChecked = 0, k, nPend = 0;
	pss_row_s rows [7] = '{'{3'h1, 7'h01}, '{3'h2, 7'h02}, '{3'h3, 7'h04},
		'{3'h4, 7'h08}, '{3'h5, 7'h10}, '{3'h6, 7'h20}, '{3'h7, 7'h40}};
	always #20 clock = ~clock;
	// one-cycle outputs caught while they stand
	always @(posedge clock) begin
		if (eventStrobe === 1'b1)
			lastKind <= eventKind;
		if (pendingChange === 1'b1)
			nPend <= nPend + 1;
	end
	pss_operands u_ops (.clock(clock), .increment(increment),
		.increment_confirm(increment_confirm), .code_bit_0(code_bit_0),
		.code_bit_1(code_bit_1), .code_bit_2(code_bit_2),
		.code_confirm(code_confirm));
	pss_selector u_dut (.clock(clock), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.increment(increment), .increment_confirm(increment_confirm),
		.code_bit_0(code_bit_0), .code_bit_1(code_bit_1),
		.code_bit_2(code_bit_2), .code_confirm(code_confirm),
		.positionOut(positionOut), .positionCode(positionCode),
		.pendingChange(pendingChange), .pendingFrom(pendingFrom),
		.pendingTo(pendingTo), .selector_alarm(selector_alarm),
		.increment_unconfirmed_alarm(increment_unconfirmed_alarm),
		.code_unconfirmed_alarm(code_unconfirmed_alarm),
		.startup_alarm(startup_alarm), .eventKind(eventKind),
		.eventStrobe(eventStrobe));
	////////////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [31:0] got, exp);
		samplesChecked++;
		if (got !== exp) begin
			nMismatch++;
			$display("[FAIL] %s expected %h seen %h", n, exp, got);
		end
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", samplesChecked, nMismatch);
		if (nMismatch == 0 && samplesChecked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do
			@(posedge clock);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask
	task automatic do_reset;
		rst_n <= 1'b0;
		repeat (20) @(posedge clock);
		rst_n <= 1'b1;
		repeat (6) @(posedge clock);
	endtask
	////////////////////////////////////////////////////////////////////
	initial begin
		psel <= 1'b0;
		penable <= 1'b0;
		pwrite <= 1'b0;
		paddr <= 8'h00;
		pwdata <= 32'h0000_0000;
		do_reset;
		apb(1'b0, `PSS_CTRL_OFS, 32'h0);
		chk("ctrl reset", rd, `PSS_CTRL_RST);
		apb(1'b0, 8'h10, 32'h0);
		chk("unmapped err", err, 1);
		chk("unmapped data", rd, 0);
		apb(1'b1, `PSS_CTRL_OFS, 32'h0000_015F);
		foreach (rows[i]) begin
			u_ops.set_code(rows[i].code);
			u_ops.pulse(2);
			chk("row code", positionCode, rows[i].code);
			chk("row onehot", positionOut, rows[i].hot);
		end
		u_ops.set_code(3'h0);
		repeat (4) @(posedge clock);
		chk("rest alarm", selector_alarm, 0);
		chk("rest pos", positionCode, 7);
		apb(1'b1, `PSS_CTRL_OFS, 32'h0000_015D);
		u_ops.set_code(3'h6);
		repeat (3) @(posedge clock);
		chk("range alarm", selector_alarm, 1);
		chk("range pos", positionCode, 7);
		u_ops.set_code(3'h4);
		u_ops.pulse(2);
		chk("code apply", positionCode, 4);
		u_ops.pulse(0);
		chk("step pre", pendingTo, 5);
		chk("step from", pendingFrom, 4);
		u_ops.pulse(0);
		chk("wrap pre", pendingTo, 1);
		chk("pending pulses", nPend, 2);
		u_ops.set_code(3'h2);
		u_ops.pulse(2);
		chk("locked out", positionCode, 4);
		u_ops.pulse(1);
		chk("step apply", positionCode, 1);
		chk("change event", lastKind, EV_CHANGE);
		u_ops.pulse(0);
		for (k = 0; k < 60000 && increment_unconfirmed_alarm !== 1'b1; k++)
			@(posedge clock);
		repeat (3) @(posedge clock);
		chk("step alarm", increment_unconfirmed_alarm, 1);
		chk("kept pos", positionCode, 1);
		chk("alarm event", lastKind, EV_INC_ALARM);
		apb(1'b1, `PSS_CTRL_OFS, 32'h0000_0157);
		u_ops.pulse(0);
		u_ops.pulse(1);
		chk("confirm ignored", positionCode, 1);
		for (k = 0; k < 60000 && positionCode !== 3'h2; k++)
			@(posedge clock);
		chk("timeout apply", positionCode, 2);
		repeat (4) @(posedge clock);
		apb(1'b0, `PSS_NV_OFS, 32'h0);
		chk("nv stored", rd[2:0], 2);
		do_reset;
		chk("restored", positionCode, 2);
		apb(1'b1, `PSS_NV_OFS, 32'h0);
		do_reset;
		chk("bad restore", positionOut, 0);
		chk("power alarm", startup_alarm, 1);
		// timeout field 0: sequences end on the next cycle
		apb(1'b1, `PSS_CTRL_OFS, 32'h0000_0057);
		u_ops.set_code(3'h3);
		repeat (2) @(posedge clock);
		chk("code alarm", code_unconfirmed_alarm, 1);
		chk("code kept", positionCode, 0);
		chk("code event", lastKind, EV_CODE_ALARM);
		apb(1'b1, `PSS_CTRL_OFS, 32'h0000_0047);
		u_ops.set_code(3'h5);
		repeat (2) @(posedge clock);
		chk("code timeout", positionCode, 5);
		apb(1'b1, `PSS_CTRL_OFS, 32'h0000_0067);
		u_ops.set_code(3'h0);
		do_reset;
		chk("sync rest", positionCode, 0);
		chk("sync alarm", startup_alarm, 1);
		rst_n <= 1'b0;
		u_ops.set_code(3'h3);
		do_reset;
		chk("sync apply", positionCode, 3);
		chk("sync clear", startup_alarm, 0);
		give_verdict;
	end
	initial begin
		repeat (90000) @(posedge clock);
		nMismatch++;
		give_verdict;
	end
endmodule
bind pss_selector pss_selector_properties u_props (.clock(clock),
	.rst_n(rst_n), .psel(psel), .penable(penable), .paddr(paddr),
	.pready(pready), .pslverr(pslverr), .positionOut(positionOut),
	.positionCode(positionCode), .selector_alarm(selector_alarm),
	.increment_unconfirmed_alarm(increment_unconfirmed_alarm),
	.startup_alarm(startup_alarm), .eventStrobe(eventStrobe));

// >>> hdl/pss_defs.svh
// Purpose: constants for the position selector switch
// Assumes: 25 MHz clock, all offsets are byte addresses
// Notes: included by the testbench and the design
`ifndef PSS_DEFS_SVH
`define PSS_DEFS_SVH
`define PSS_CLK_HZ 25000000
`define PSS_MS_CYC (`PSS_CLK_HZ / 1000)
`define PSS_ALARM_MS 3000
`define PSS_CTRL_OFS 8'h00
`define PSS_STAT_OFS 8'h04
`define PSS_EVT_OFS 8'h08
`define PSS_NV_OFS 8'h0C
`define PSS_CTRL_RST 32'h0000_1307
`define PSS_NV_RST 32'h0000_0000
`define PSS_TOP_LSB 0
`define PSS_INCACK_BIT 3
`define PSS_CODEACK_BIT 4
`define PSS_SYNC_BIT 5
`define PSS_EVEN_BIT 6
`define PSS_TMO_LSB 8
`endif

// >>> hdl/pss_pkg.sv
// Purpose: types for the position selector switch
// Assumes: pss_defs.svh holds the numbers
// Notes: none
package pss_pkg;
	typedef struct packed {
		logic [15:0] timeoutMs;
		logic evtEnable;
		logic syncPowerUp;
		logic codeConfirmMode;
		logic incConfirmMode;
		logic [2:0] topPos;
	} pss_cfg_s;
	typedef enum logic [1:0] {
		IDLE = 2'b00,
		INC_SEQ = 2'b01,
		CODE_SEQ = 2'b10
	} pss_state_e;
	typedef enum logic [1:0] {
		EV_NONE = 2'b00,
		EV_CHANGE = 2'b01,
		EV_INC_ALARM = 2'b10,
		EV_CODE_ALARM = 2'b11
	} pss_evt_e;
endpackage

// >>> hdl/pss_selector.sv
// Purpose: multi-position selector replacing a rotary switch
// Assumes: control inputs synchronous to clock; APB register access
// Notes: stored word and settings are kept through rst_n;
// the power-up action runs once after each release
// Overview of operation
// - top position bounds selector, wraps to 1
// - code out of range: no change, 3 s alarm
// - increment timeout mode applies after inactivity
// - only increment edges or code changes on the running path restart the timeout
// - confirm mode: no confirm before timeout discards
// - unconfirmed increment selection pulses alarm 3 s
// - increment rising edge advances preselection with wrap
// - increment edge restarts timer, flags pending change
// - increment confirm edge applies; ignored in timeout
// - code is unsigned binary, bit 2 MSB
// - all-zero code does nothing except restart the code-path timeout
// - code timeout mode applies after last change
// - code confirm edge applies; ignored in timeout
// - the two paths lock each other out
// - unconfirmed code selection pulses alarm 3 s
// - each confirm input acts on its own path
// - position stored; restore mode reloads it
// - synchronize mode applies code at power-up
// - sync with bad code gives 0 and alarm
// - restore with bad stored value: 0, alarm
// - log changes and both unconfirmed alarms
// - step by increment or set by code
`timescale 1ns/10ps
`include "pss_defs.svh"
module pss_selector (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic increment,
	input wire logic increment_confirm,
	input wire logic code_bit_0,
	input wire logic code_bit_1,
	input wire logic code_bit_2,
	input wire logic code_confirm,
	output logic [7:1] positionOut,
	output logic [2:0] positionCode,
	output logic pendingChange,
	output logic [2:0] pendingFrom,
	output logic [2:0] pendingTo,
	output logic selector_alarm,
	output logic increment_unconfirmed_alarm,
	output logic code_unconfirmed_alarm,
	output logic startup_alarm,
	output pss_pkg::pss_evt_e eventKind,
	output logic eventStrobe
);
	import pss_pkg::*;

	////////////////////////////////////////////////////////////////////
	// registers and bus
	// settings and stored word keep their contents through rst_n
	// timeout field moves down from bit 8 to struct bit 7
	pss_cfg_s cfg_reg = pss_cfg_s'(23'(
		((`PSS_CTRL_RST >> 1) & 32'h007F_FF80) |
		(`PSS_CTRL_RST & 32'h0000_007F)));
	logic [2:0] nv_reg = 3'(`PSS_NV_RST);
	logic [2:0] pos_reg, pos_next;
	logic [2:0] pre_reg, pre_next;
	pss_state_e state_reg, state_next;
	logic [15:0] cyc_reg;
	logic [15:0] ms_reg;
	logic [11:0] alarmCnt_reg [0:2];
	logic [2:0] alarmFire;
	logic [2:0] lastFrom_reg, lastTo_reg;
	logic [1:0] lastEvt_reg;
	logic [7:0] evtCount_reg;
	logic startup_reg;
	logic powered_reg;
	logic incPrev_reg, incAckPrev_reg, codeAckPrev_reg;
	logic [2:0] codePrev_reg;
	logic [31:0] cfgWord;
	logic apply, incAlarm, codeAlarm, rangeAlarm, restartTimer;

	wire apbWrite = psel && penable && pwrite;
	wire selCtrl = paddr == `PSS_CTRL_OFS;
	wire selStat = paddr == `PSS_STAT_OFS;
	wire selEvt = paddr == `PSS_EVT_OFS;
	wire selNv = paddr == `PSS_NV_OFS;
	wire mapped = selCtrl || selStat || selEvt || selNv;
	assign cfgWord = {8'h00, cfg_reg.timeoutMs, 1'b0,
		cfg_reg.evtEnable,
		cfg_reg.syncPowerUp,
		cfg_reg.codeConfirmMode,
		cfg_reg.incConfirmMode,
		cfg_reg.topPos};
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;
	wire [31:0] statWord = {16'h0000, 4'h0,
		startup_reg,
		state_reg,
		pre_reg,
		1'b0,
		pos_reg,
		2'h0};
	wire [31:0] evtWord = {16'h0000,
		evtCount_reg,
		lastEvt_reg,
		lastFrom_reg,
		lastTo_reg};
	wire [31:0] rdMux = selCtrl ? cfgWord :
		selStat ? statWord :
		selEvt ? evtWord :
		selNv ? {29'h0, nv_reg} :
		32'h0000_0000;

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable) begin
			prdata <= rdMux;
		end
	end

	always_ff @(posedge clock) begin
		if (rst_n && apbWrite && selCtrl) begin
			cfg_reg <= pss_cfg_s'({pwdata[`PSS_TMO_LSB +: 16],
				pwdata[6:0]});
		end
	end

	////////////////////////////////////////////////////////////////////
	// input sampling and millisecond tick
	wire [2:0] code = {code_bit_2, code_bit_1, code_bit_0};
	wire incRise = increment && !incPrev_reg;
	wire incAckRise = increment_confirm && !incAckPrev_reg;
	wire codeAckRise = code_confirm && !codeAckPrev_reg;
	// no code change is seen on the power-up edge
	wire codeChange = powered_reg && code != codePrev_reg;
	// one tick per millisecond
	wire msTick = cyc_reg == 16'(`PSS_MS_CYC - 1);
	wire codeValid = code != 3'h0 && code <= cfg_reg.topPos;
	wire timedOut = ms_reg >= cfg_reg.timeoutMs;
	wire [2:0] preInc = (pre_reg >= cfg_reg.topPos) ? 3'h1 :
		pre_reg + 3'h1;

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			incPrev_reg <= 1'b0;
			incAckPrev_reg <= 1'b0;
			codeAckPrev_reg <= 1'b0;
			codePrev_reg <= 3'h0;
			cyc_reg <= 16'h0000;
		end else begin
			incPrev_reg <= increment;
			incAckPrev_reg <= increment_confirm;
			codeAckPrev_reg <= code_confirm;
			codePrev_reg <= code;
			// timeout counts whole ms from the last activity
			cyc_reg <= (msTick || restartTimer) ? 16'h0000 :
				cyc_reg + 16'h0001;
		end
	end

	////////////////////////////////////////////////////////////////////
	// sequence state machine
	// confirm beats timeout when both land in one cycle

	always_comb begin
		state_next = state_reg;
		pre_next = pre_reg;
		apply = 1'b0;
		incAlarm = 1'b0;
		codeAlarm = 1'b0;
		rangeAlarm = 1'b0;
		restartTimer = 1'b0;
		unique case (state_reg)
			IDLE: begin
				if (incRise) begin
					state_next = INC_SEQ;
					pre_next = (pos_reg >= cfg_reg.topPos) ? 3'h1 :
						pos_reg + 3'h1;
					restartTimer = 1'b1;
				end else if (codeChange && code != 3'h0) begin
					if (codeValid) begin
						state_next = CODE_SEQ;
						pre_next = code;
						restartTimer = 1'b1;
					end else begin
						rangeAlarm = 1'b1;
					end
				end
			end
			INC_SEQ: begin
				if (incRise) begin
					pre_next = preInc;
					restartTimer = 1'b1;
				end else if (cfg_reg.incConfirmMode && incAckRise) begin
					apply = 1'b1;
					state_next = IDLE;
				end else if (timedOut) begin
					state_next = IDLE;
					if (cfg_reg.incConfirmMode) begin
						incAlarm = 1'b1;
					end else begin
						apply = 1'b1;
					end
				end
			end
			CODE_SEQ: begin
				if (codeChange) begin
					restartTimer = 1'b1;
					if (codeValid) begin
						pre_next = code;
					end else if (code != 3'h0) begin
						rangeAlarm = 1'b1;
					end
				end else if (cfg_reg.codeConfirmMode && codeAckRise) begin
					apply = 1'b1;
					state_next = IDLE;
				end else if (timedOut) begin
					state_next = IDLE;
					if (cfg_reg.codeConfirmMode) begin
						codeAlarm = 1'b1;
					end else begin
						apply = 1'b1;
					end
				end
			end
			default: begin
				state_next = IDLE;
			end
		endcase
	end

	assign pos_next = apply ? pre_reg : pos_reg;

	// timer halts once expired, so it cannot wrap
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state_reg <= IDLE;
			pre_reg <= 3'h0;
			ms_reg <= 16'h0000;
		end else begin
			state_reg <= state_next;
			pre_reg <= pre_next;
			if (restartTimer) begin
				ms_reg <= 16'h0000;
			end else if (msTick && !timedOut) begin
				ms_reg <= ms_reg + 16'h0001;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// position, power-up and storage
	wire nvValid = nv_reg != 3'h0 && nv_reg <= cfg_reg.topPos;

	// first edge after release runs the power-up action
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			pos_reg <= 3'h0;
			powered_reg <= 1'b0;
			startup_reg <= 1'b0;
		end else if (!powered_reg) begin
			powered_reg <= 1'b1;
			if (cfg_reg.syncPowerUp) begin
				pos_reg <= codeValid ? code : 3'h0;
				startup_reg <= !codeValid;
			end else begin
				pos_reg <= nvValid ? nv_reg : 3'h0;
				startup_reg <= !nvValid;
			end
		end else begin
			pos_reg <= pos_next;
			if (apply) begin
				startup_reg <= 1'b0;
			end
		end
	end

	// stored word survives rst_n; only a bus write or an apply moves it
	always_ff @(posedge clock) begin
		if (apply) begin
			nv_reg <= pre_reg;
		end else if (rst_n && apbWrite && selNv) begin
			nv_reg <= pwdata[2:0];
		end
	end

	////////////////////////////////////////////////////////////////////
	// outputs
	// position 0 drives no output
	genvar gi;
	generate
		for (gi = 1; gi <= 7; gi++) begin : g_pos
			always_ff @(posedge clock) begin
				if (!rst_n) begin
					positionOut[gi] <= 1'b0;
				end else begin
					positionOut[gi] <= pos_reg == 3'(gi);
				end
			end
		end
	endgenerate

	// alarm counters: 0 range, 1 step, 2 code
	// a new alarm restarts its full span
	assign alarmFire = {codeAlarm, incAlarm, rangeAlarm};
	generate
		for (gi = 0; gi < 3; gi++) begin : g_alarm
			always_ff @(posedge clock) begin
				if (!rst_n) begin
					alarmCnt_reg[gi] <= 12'h000;
				end else if (alarmFire[gi]) begin
					alarmCnt_reg[gi] <= 12'(`PSS_ALARM_MS);
				end else if (msTick && alarmCnt_reg[gi] != 12'h000) begin
					alarmCnt_reg[gi] <= alarmCnt_reg[gi] - 12'h001;
				end
			end
		end
	endgenerate

	// events carry the position before and after
	wire logEvt = cfg_reg.evtEnable && (apply || incAlarm || codeAlarm);
	wire [1:0] evtCode = apply ? EV_CHANGE : incAlarm ? EV_INC_ALARM :
		EV_CODE_ALARM;

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			positionCode <= 3'h0;
			pendingChange <= 1'b0;
			pendingFrom <= 3'h0;
			pendingTo <= 3'h0;
			selector_alarm <= 1'b0;
			increment_unconfirmed_alarm <= 1'b0;
			code_unconfirmed_alarm <= 1'b0;
			startup_alarm <= 1'b0;
			eventKind <= EV_NONE;
			eventStrobe <= 1'b0;
			lastEvt_reg <= 2'h0;
			lastFrom_reg <= 3'h0;
			lastTo_reg <= 3'h0;
			evtCount_reg <= 8'h00;
		end else begin
			positionCode <= pos_reg;
			pendingChange <= state_next == INC_SEQ && incRise;
			if (state_next == INC_SEQ && incRise) begin
				pendingFrom <= pos_reg;
				pendingTo <= pre_next;
			end
			selector_alarm <= alarmCnt_reg[0] != 12'h000;
			increment_unconfirmed_alarm <= alarmCnt_reg[1] != 12'h000;
			code_unconfirmed_alarm <= alarmCnt_reg[2] != 12'h000;
			startup_alarm <= startup_reg;
			eventStrobe <= logEvt;
			eventKind <= logEvt ? pss_evt_e'(evtCode) : EV_NONE;
			if (logEvt) begin
				lastEvt_reg <= evtCode;
				lastFrom_reg <= pos_reg;
				lastTo_reg <= pre_reg;
				evtCount_reg <= evtCount_reg + 8'h01;
			end
		end
	end
endmodule
